// ===== hdl/btp_consts.svh
// constants of the buzzer tone generator: offsets, fields, resets, timing
// assumes a 100 MHz system clock; included by the package and the top module
`ifndef BTP_CONSTS_SVH
`define BTP_CONSTS_SVH

// system clock period in ns
`define BTP_SYS_CLK_NS 10
// module tick period in ns (50 MHz)
`define BTP_TICK_NS 20
// system clocks per module tick
`define BTP_TICK_DIV (`BTP_TICK_NS / `BTP_SYS_CLK_NS)
// tone period in us and active share in percent
`define BTP_PERIOD_US 500
`define BTP_DUTY_PCT 50
// period and active phase in module ticks
`define BTP_PERIOD_TICKS ((`BTP_PERIOD_US * 1000) / `BTP_TICK_NS)
`define BTP_ACTIVE_TICKS ((`BTP_PERIOD_TICKS * `BTP_DUTY_PCT) / 100)

// register byte offsets
`define BTP_CTRL_OFS 4'h0
`define BTP_STATUS_OFS 4'h4
`define BTP_COUNT_OFS 4'h8

// control fields
`define BTP_CTRL_SW_EN_BIT 0
`define BTP_CTRL_PIN_EN_BIT 1
// status fields
`define BTP_STAT_RUN_BIT 0
`define BTP_STAT_OUT_BIT 1
`define BTP_STAT_ALARM_BIT 2

// reset values
`define BTP_CTRL_RESET 2'h0
`define BTP_RDATA_UNMAPPED 32'h0000_0000

`endif

// ===== hdl/btp_pkg.sv
// types of the buzzer tone generator
// assumes btp_consts.svh sits beside it
`include "btp_consts.svh"

package btp_pkg;

    // control register contents
    typedef struct packed {
        logic pin_en; // sound while the abnormality pin is raised
        logic sw_en; // sound on software request
    } btp_ctrl_t;

    // phase of the tone sequencer
    typedef enum logic [1:0] {
        BTP_IDLE = 2'b00,
        BTP_HIGH = 2'b01,
        BTP_LOW = 2'b10
    } btp_state_t;

    // avalon request as one bundle
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } btp_req_t;

endpackage

// ===== hdl/btp_buzzer_pwm.sv
// buzzer tone generator: one 2 kHz, 50 % PWM channel, restarted in its high phase each time sounding begins
// assumes a 100 MHz SYS_CLK, an Avalon-MM master and an abnormality pin
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "btp_consts.svh"

module btp_buzzer_pwm
    import btp_pkg::*;
#(
    parameter int PERIOD_TICKS = `BTP_PERIOD_TICKS,
    parameter int ACTIVE_TICKS = `BTP_ACTIVE_TICKS,
    parameter int CNT_W = 15
)
(
    input wire logic SYS_CLK, // 100 MHz system clock
    input wire logic RESET_N, // asynchronous reset, low active
    input wire logic [3:0] AVS_ADDRESS, // byte address
    input wire logic AVS_READ, // read request
    input wire logic AVS_WRITE, // write request
    input wire logic [3:0] AVS_BYTEENABLE, // byte lanes of a write
    input wire logic [31:0] AVS_WRITEDATA, // write data
    output logic [31:0] AVS_READDATA, // read data
    output logic AVS_WAITREQUEST, // stall until answered
    input wire logic ALARM_IN, // abnormality reported, high active
    output logic BUZZER_PWM_OUTPUT // drive to the buzzer switch
);

    localparam logic [CNT_W-1:0] LAST_TICK = CNT_W'(PERIOD_TICKS - 1);
    localparam logic [CNT_W-1:0] LAST_HIGH = CNT_W'(ACTIVE_TICKS - 1);
    localparam int DIV_W = 2;
    localparam logic [DIV_W-1:0] LAST_DIV = DIV_W'(`BTP_TICK_DIV - 1);

    btp_req_t req;
    btp_ctrl_t ctrl_q;
    btp_state_t state_q;
    btp_state_t state_d;
    logic ack_q;
    logic take;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic [DIV_W-1:0] div_q;
    logic tick;
    logic [CNT_W-1:0] cnt_q;
    logic at_last;
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic alarm_q;
    logic sound;
    logic pwm_q;

    // word decode shared by read and write paths
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
        hit = (addr[3:2] == ofs[3:2]);
    endfunction

    // bundle the bus request
    assign req.read = AVS_READ;
    assign req.write = AVS_WRITE;
    assign req.address = AVS_ADDRESS;
    assign req.byteenable = AVS_BYTEENABLE;
    assign req.writedata = AVS_WRITEDATA;

    // one wait state on every access, then the answer
    assign AVS_WAITREQUEST = (req.read | req.write) & ~ack_q;
    assign take = (req.read | req.write) & ack_q;

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            ack_q <= 1'b0;
        else
            ack_q <= (req.read | req.write) & ~ack_q;
    end

    // control register, written when the access completes
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            ctrl_q <= `BTP_CTRL_RESET;
        else if (take && req.write && req.byteenable[0] && hit(req.address, `BTP_CTRL_OFS))
        begin
            ctrl_q.sw_en <= req.writedata[`BTP_CTRL_SW_EN_BIT];
            ctrl_q.pin_en <= req.writedata[`BTP_CTRL_PIN_EN_BIT];
        end
    end

    // read mux; unmapped words read zero
    always_comb
    begin
        rdata_d = `BTP_RDATA_UNMAPPED;
        if (hit(req.address, `BTP_CTRL_OFS))
        begin
            rdata_d[`BTP_CTRL_SW_EN_BIT] = ctrl_q.sw_en;
            rdata_d[`BTP_CTRL_PIN_EN_BIT] = ctrl_q.pin_en;
        end
        else if (hit(req.address, `BTP_STATUS_OFS))
        begin
            rdata_d[`BTP_STAT_RUN_BIT] = (state_q != BTP_IDLE);
            rdata_d[`BTP_STAT_OUT_BIT] = pwm_q;
            rdata_d[`BTP_STAT_ALARM_BIT] = alarm_q;
        end
        else if (hit(req.address, `BTP_COUNT_OFS))
            rdata_d[CNT_W-1:0] = cnt_q;
    end

    // read data captured in the wait cycle, held through the answer
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            rdata_q <= `BTP_RDATA_UNMAPPED;
        else if (req.read && !ack_q)
            rdata_q <= rdata_d;
    end

    assign AVS_READDATA = rdata_q;

    // abnormality pin: three stages, accepted when stages two and three agree
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end
        else
        begin
            sync1_q <= ALARM_IN;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            alarm_q <= 1'b0;
        else if (sync2_q == sync3_q)
            alarm_q <= sync3_q;
    end

    assign sound = ctrl_q.sw_en | (ctrl_q.pin_en & alarm_q);

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            div_q <= '0;
        else if (state_q == BTP_IDLE || div_q == LAST_DIV)
            div_q <= '0;
        else
            div_q <= div_q + DIV_W'(1);
    end

    assign tick = (state_q != BTP_IDLE) && (div_q == LAST_DIV);
    assign at_last = (cnt_q == LAST_TICK);

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            cnt_q <= '0;
        else if (state_q == BTP_IDLE)
            cnt_q <= '0;
        else if (tick)
            cnt_q <= at_last ? '0 : cnt_q + CNT_W'(1);
    end

    // sequencer: high phase, low phase, repeat while sounding
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            BTP_IDLE:
                if (sound)
                    state_d = BTP_HIGH;
            BTP_HIGH:
                if (!sound)
                    state_d = BTP_IDLE;
                else if (tick && cnt_q == LAST_HIGH)
                    state_d = BTP_LOW;
            BTP_LOW:
                if (!sound)
                    state_d = BTP_IDLE;
                else if (tick && at_last)
                    state_d = BTP_HIGH;
            default:
                state_d = BTP_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            state_q <= BTP_IDLE;
        else
            state_q <= state_d;
    end

    // high for the first half of each period
    // low at reset and while idle
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            pwm_q <= 1'b0;
        else
            pwm_q <= (state_d == BTP_HIGH);
    end

    assign BUZZER_PWM_OUTPUT = pwm_q;

endmodule

`default_nettype wire

// ===== verification/btp_pwm_properties.sv
// checks of bus timing, tone phases and stop
// sees the top ports only; bound at the foot
`timescale 1ns/100ps
`default_nettype none
module btp_pwm_props #(
    parameter int PERIOD_TICKS = 25000,
    parameter int ACTIVE_TICKS = 12500
)
(
    input wire logic SYS_CLK, // clock
    input wire logic RESET_N, // reset
    input wire logic [3:0] AVS_ADDRESS, // address
    input wire logic AVS_READ, // read
    input wire logic AVS_WRITE, // write
    input wire logic [3:0] AVS_BYTEENABLE, // lanes
    input wire logic [31:0] AVS_WRITEDATA, // data in
    input wire logic [31:0] AVS_READDATA, // data out
    input wire logic AVS_WAITREQUEST, // stall
    input wire logic BUZZER_PWM_OUTPUT // tone
);
    localparam int HI = 2 * ACTIVE_TICKS;
    localparam int LO = 2 * (PERIOD_TICKS - ACTIVE_TICKS);
    logic sw_q, pin_q, rq, rd_end;
    logic run_q;
    logic [15:0] cnt_q;
    assign rq = AVS_READ || AVS_WRITE;
    assign rd_end = AVS_READ && !AVS_WAITREQUEST;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    // control shadow and length of the current level
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            {pin_q, sw_q} <= 2'h0;
            cnt_q <= 16'h0;
            run_q <= 1'b0;
        end
        else
        begin
            if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[3:2] == 2'h0 && AVS_BYTEENABLE[0])
                {pin_q, sw_q} <= AVS_WRITEDATA[1:0];
            cnt_q <= $changed(BUZZER_PWM_OUTPUT) ? 16'h1 : cnt_q + 16'h1;
            // a fall has been seen while software keeps the tone on, so the current low phase is timed in full
            if (!sw_q)
                run_q <= 1'b0;
            else if ($fell(BUZZER_PWM_OUTPUT))
                run_q <= 1'b1;
        end
    end
    a_wait_first: assert property ($rose(rq) |-> AVS_WAITREQUEST) else $error("no wait");
    a_one_wait: assert property (rq && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("long wait");
    a_wait_idle: assert property (!rq |-> !AVS_WAITREQUEST) else $error("idle wait");
    a_unmapped_zero: assert property (rd_end && AVS_ADDRESS[3:2] == 2'h3 |-> AVS_READDATA == 32'h0) else $error("hole");
    a_ctrl_read: assert property (rd_end && AVS_ADDRESS[3:2] == 2'h0 |-> AVS_READDATA == {30'h0, pin_q, sw_q}) else $error("ctrl");
    a_high_len: assert property ($fell(BUZZER_PWM_OUTPUT) && sw_q |-> cnt_q == HI) else $error("high len");
    a_low_len: assert property ($rose(BUZZER_PWM_OUTPUT) && run_q |-> cnt_q == LO) else $error("low len");
    a_start_high: assert property ($rose(sw_q) && !pin_q && !BUZZER_PWM_OUTPUT |=> BUZZER_PWM_OUTPUT) else $error("start");
    a_stop_low: assert property ($fell(sw_q) && !pin_q |=> !BUZZER_PWM_OUTPUT[*3]) else $error("stop");
    c_tone: cover property ($fell(BUZZER_PWM_OUTPUT) && sw_q);
    c_hole: cover property (rd_end && AVS_ADDRESS[3:2] == 2'h3);
    c_stop: cover property ($fell(sw_q));
endmodule
bind btp_buzzer_pwm btp_pwm_props #(.PERIOD_TICKS(PERIOD_TICKS), .ACTIVE_TICKS(ACTIVE_TICKS)) i_props (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .BUZZER_PWM_OUTPUT(BUZZER_PWM_OUTPUT));
`default_nettype wire

// ===== verification/btp_buzzer_stage.sv
// buzzer switch stage: counts closures
// driven by the tone output alone
`timescale 1ns/100ps
`default_nettype none
module btp_buzzer_stage (
    input wire logic DRIVE, // switch gate
    output var int RISES // closures
);
    // each rise closes the switch once
    initial RISES = 0;
    always @(posedge DRIVE) RISES++;
endmodule
`default_nettype wire

// ===== verification/btp_buzzer_pwm_tb_top.sv
// bench: bus tasks, tone timing, alarm path
// period shortened to 20 ticks
`timescale 1ns/100ps
`default_nettype none
module btp_buzzer_pwm_tb_top
    import btp_pkg::*;
;
    localparam int P = 20;
    localparam int A = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic alarm = 1'b0;
    btp_req_t req = '0;
    logic [31:0] rdata, r;
    logic wreq, buzz;
    int bad_count = 0, n_tests = 0, ctrl_m = 0, rises, h, l;
    // clock
    always #5 clk = ~clk;
    btp_buzzer_pwm #(.PERIOD_TICKS(P), .ACTIVE_TICKS(A)) i_dut (.SYS_CLK(clk), .RESET_N(rst_n),
        .AVS_ADDRESS(req.address), .AVS_READ(req.read), .AVS_WRITE(req.write), .AVS_BYTEENABLE(req.byteenable),
        .AVS_WRITEDATA(req.writedata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .ALARM_IN(alarm),
        .BUZZER_PWM_OUTPUT(buzz));
    btp_buzzer_stage i_stage (.DRIVE(buzz), .RISES(rises));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        bad_count += int'(g !== e);
        if (g !== e)
            $display("FAIL %s exp %h got %h", nm, e, g);
    endtask
    // one access held until waitrequest low; model keeps control
    task automatic bus(logic w, logic [3:0] a, logic [3:0] be, logic [31:0] d);
        @(posedge clk);
        req <= '{!w, w, a, be, d};
        do @(posedge clk); while (wreq !== 1'b0);
        r = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        if (w && a[3:2] == 2'h0 && be[0])
            ctrl_m = d[1:0];
    endtask
    // clocks spent at one level
    task automatic len(logic lv, output int n);
        n = 0;
        while (buzz === lv)
        begin
            n++;
            @(posedge clk);
        end
    endtask
    task automatic conclude();
        if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #200000 bad_count++;
        conclude();
    end
    initial
    begin
        void'($urandom(32'h30E6));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, 4'h0, 4'hF, 32'h0);
        chk("ctrl", ctrl_m, r);
        chk("out", 0, buzz);
        bus(1'b1, 4'h8, 4'hF, $urandom);
        bus(1'b1, 4'h0, 4'hE, $urandom | 32'h3);
        bus(1'b1, 4'hC, 4'hF, $urandom);
        bus(1'b0, 4'hC, 4'hF, 32'h0);
        chk("hole", 0, r);
        bus(1'b0, 4'h0, 4'hF, 32'h0);
        chk("ctrl", ctrl_m, r);
        bus(1'b1, 4'h0, 4'h1, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            while (buzz !== 1'b1) @(posedge clk);
            len(1'b1, h);
            len(1'b0, l);
            chk("high", 2 * A, h);
            chk("low", 2 * (P - A), l);
        end
        bus(1'b1, 4'h0, 4'h1, 32'h0);
        repeat (2) @(posedge clk);
        chk("stop", 0, buzz);
        chk("rises", 4, rises);
        bus(1'b1, 4'h0, 4'h1, 32'h2);
        bus(1'b0, 4'h0, 4'hF, 32'h0);
        chk("ctrl", ctrl_m, r);
        chk("quiet", 0, buzz);
        bus(1'b0, 4'h4, 4'hF, 32'h0);
        chk("status", 0, r);
        bus(1'b0, 4'h8, 4'hF, 32'h0);
        chk("count", 0, r);
        alarm <= 1'b1;
        while (buzz !== 1'b1) @(posedge clk);
        len(1'b1, h);
        chk("alarm", 2 * A, h);
        bus(1'b0, 4'h4, 4'hF, 32'h0);
        chk("status", 32'h5, r);
        alarm <= 1'b0;
        repeat (6) @(posedge clk);
        bus(1'b0, 4'h4, 4'hF, 32'h0);
        chk("status", 0, r);
        chk("silent", 0, buzz);
        conclude();
    end
endmodule
`default_nettype wire
